//--- rtl/cldi_top.sv
// Cold load pick-up and magnetising inrush detector with register port and interrupt
// Notes on behaviour
// (RL1) Cold load detection when all phases idle, then one exceeds pick-up within 80 ms.
// (RL2) Detection lasts until maximum time expires or current drops below pick-up.
// (RL3) Inrush needs the same rise plus a phase harmonic ratio above threshold.
// (RL4) Zero harmonic threshold makes inrush detection equal to cold load detection.
// (RL5) Inrush blocking starts on the rise alone, before harmonic result exists.
// (RL6) After first full cycle keep inrush if ratio significant, else release.
// (RL7) Harmonic decision only from a complete cycle result; none before.
// (RL8) Cold load status shows start while active, trip after maximum time.
// (RL9) Inrush status shows start while detected, trip on maximum time.
// (RL10) Supervised value is max phase current, readable primary scaled with thresholds.
// (RL11) No detection unless current was first below idle threshold.
// (RL12) No detection when current lingers between thresholds beyond 80 ms.
// (RL13) Both detections routable to output matrix and blocking matrix.
// (RL14) After a detection, all phases must return below idle before the next.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`include "cldi_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module cldi_top #(
  parameter int P_DW     = 16,
  parameter int P_RW     = 16,
  parameter int P_MS_CYC = `CLDI_MS_CYC
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_resetn,
  input  wire logic [P_DW-1:0]      i_cur_a,
  input  wire logic [P_DW-1:0]      i_cur_b,
  input  wire logic [P_DW-1:0]      i_cur_c,
  input  wire logic [P_RW-1:0]      i_ratio_a,
  input  wire logic [P_RW-1:0]      i_ratio_b,
  input  wire logic [P_RW-1:0]      i_ratio_c,
  input  wire logic                 i_cycle_done,
  input  wire cldi_pkg::cldi_addr_t i_addr,
  input  wire cldi_pkg::cldi_word_t i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output var  cldi_pkg::cldi_word_t o_rdata,
  output logic                      o_irq,
  output logic                      o_cold_outmx,
  output logic                      o_cold_blkmx,
  output logic                      o_inrush_outmx,
  output logic                      o_inrush_blkmx
);
  import cldi_pkg::*;

  localparam int MSW = $clog2(P_MS_CYC + 1);

  logic              rst_meta_r;
  logic              rst_n_r;
  cldi_state_t       state_r;
  cldi_state_t       state_nxt;
  logic [MSW-1:0]    ms_cnt_r;
  logic [6:0]        trans_cnt_r;
  logic [15:0]       act_cnt_r;
  logic              harm_pend_r;
  logic              harm_keep_r;
  logic              inr_at_to_r;
  logic              en_r;
  logic [P_DW-1:0]   idle_thr_r;
  logic [P_DW-1:0]   pick_thr_r;
  logic [P_RW-1:0]   harm_thr_r;
  logic [15:0]       max_time_r;
  logic [3:0]        route_r;
  logic [15:0]       scale_r;
  logic [P_DW-1:0]   max_cur_r;
  cldi_event_t       irq_stat_r;
  cldi_event_t       irq_stat_nxt;
  cldi_event_t       irq_mask_r;
  cldi_event_t       events;
  cldi_word_t        rd_mux;
  logic [P_DW-1:0]   max_ab;
  logic [P_DW-1:0]   max_cur;
  logic              all_idle;
  logic              above_pick;
  logic              ms_tick;
  logic              trans_exp;
  logic              act_exp;
  logic              harm_hit;
  logic              enter_act;
  logic              cold_det;
  logic              inr_det;
  logic              cold_trip;
  logic              inr_trip;
  logic              inr_release;
  logic              wr_ctrl;
  logic              rd_stat;

  // Reset release through two flip-flops
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // (RL10) Supervised value is the largest phase current
  assign max_ab     = (i_cur_a > i_cur_b) ? i_cur_a : i_cur_b;
  assign max_cur    = (max_ab > i_cur_c) ? max_ab : i_cur_c;
  assign all_idle   = (max_cur < idle_thr_r);
  assign above_pick = (max_cur > pick_thr_r);

  // (RL4) Zero threshold hits
  // (RL3) Any phase ratio above threshold; zero threshold always hits
  assign harm_hit = (harm_thr_r == '0) || (i_ratio_a > harm_thr_r) ||
                    (i_ratio_b > harm_thr_r) || (i_ratio_c > harm_thr_r);

  // Millisecond timing
  assign ms_tick   = (ms_cnt_r == MSW'(P_MS_CYC - 1));
  assign trans_exp = (trans_cnt_r >= 7'(`CLDI_TRANS_MS));
  assign act_exp   = (act_cnt_r >= max_time_r);

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      // (RL11) Arm only once every phase is idle
      CLDI_WAIT_IDLE: begin
        if (all_idle) state_nxt = CLDI_ARMED;
      end
      // (RL1) Direct rise to pick-up
      CLDI_ARMED: begin
        if (above_pick) state_nxt = CLDI_ACTIVE;
        else if (!all_idle) state_nxt = CLDI_TRANSIT;
      end
      // (RL12) Lingering too long locks out
      CLDI_TRANSIT: begin
        if (above_pick) state_nxt = CLDI_ACTIVE;
        else if (all_idle) state_nxt = CLDI_ARMED;
        else if (trans_exp) state_nxt = CLDI_WAIT_IDLE;
      end
      // (RL2) End on drop below pick-up or timeout
      CLDI_ACTIVE: begin
        if (!above_pick) state_nxt = CLDI_WAIT_IDLE;
        else if (act_exp) state_nxt = CLDI_TIMEOUT;
      end
      // (RL14) Re-arm needs a new idle period
      CLDI_TIMEOUT: begin
        if (!above_pick) state_nxt = CLDI_WAIT_IDLE;
      end
      default: state_nxt = CLDI_WAIT_IDLE;
    endcase
    if (!en_r) state_nxt = CLDI_WAIT_IDLE;
  end

  // (RL8) (RL9) Start and trip states
  assign enter_act   = (state_nxt == CLDI_ACTIVE) && (state_r != CLDI_ACTIVE);
  assign cold_det    = (state_r == CLDI_ACTIVE);
  assign inr_det     = cold_det && (harm_pend_r || harm_keep_r);
  assign cold_trip   = (state_r == CLDI_TIMEOUT);
  assign inr_trip    = cold_trip && inr_at_to_r;
  assign inr_release = cold_det && harm_pend_r && i_cycle_done && !harm_hit;

  // State register and millisecond prescaler restarted on every state change
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r  <= CLDI_WAIT_IDLE;
      ms_cnt_r <= '0;
    end else begin
      state_r  <= state_nxt;
      ms_cnt_r <= (ms_tick || (state_nxt != state_r)) ? '0 : MSW'(ms_cnt_r + 1'b1);
    end
  end

  // (RL12) Transition window count in milliseconds
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) trans_cnt_r <= '0;
    else if (state_r != CLDI_TRANSIT) trans_cnt_r <= '0;
    else if (ms_tick && !trans_exp) trans_cnt_r <= 7'(trans_cnt_r + 1'b1);
  end

  // (RL2) Active time count in milliseconds
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) act_cnt_r <= '0;
    else if (state_r != CLDI_ACTIVE) act_cnt_r <= '0;
    else if (ms_tick && !act_exp) act_cnt_r <= 16'(act_cnt_r + 1'b1);
  end

  // (RL5) Rise alone starts inrush; (RL7) decision waits for a full cycle
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      harm_pend_r <= 1'b0;
      harm_keep_r <= 1'b0;
    end else if (enter_act) begin
      harm_pend_r <= 1'b1;
      harm_keep_r <= 1'b0;
    end else if (cold_det && i_cycle_done) begin
      // (RL6) Keep or release after the cycle
      harm_pend_r <= 1'b0;
      harm_keep_r <= harm_hit;
    end
  end

  // (RL9) Remember whether inrush was live at timeout
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) inr_at_to_r <= 1'b0;
    else if (cold_det && (state_nxt == CLDI_TIMEOUT)) inr_at_to_r <= inr_det;
    else if (!cold_trip) inr_at_to_r <= 1'b0;
  end

  // Register decode
  assign wr_ctrl = i_wr && (i_addr == `CLDI_A_CTRL);
  assign rd_stat = i_rd && (i_addr == `CLDI_A_IRQ_STAT);

  // Setting registers written by software
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      en_r       <= `CLDI_R_CTRL;
      idle_thr_r <= P_DW'(`CLDI_R_IDLE);
      pick_thr_r <= P_DW'(`CLDI_R_PICKUP);
      harm_thr_r <= P_RW'(`CLDI_R_HARM);
      max_time_r <= `CLDI_R_MAX_ACTIVE_TIME;
      route_r    <= `CLDI_R_ROUTE;
      scale_r    <= `CLDI_R_SCALE;
      irq_mask_r <= `CLDI_R_MASK;
    end else if (i_wr) begin
      if (wr_ctrl) en_r <= i_wdata[`CLDI_B_EN];
      if (i_addr == `CLDI_A_IDLE) idle_thr_r <= i_wdata[P_DW-1:0];
      if (i_addr == `CLDI_A_PICKUP) pick_thr_r <= i_wdata[P_DW-1:0];
      if (i_addr == `CLDI_A_HARM) harm_thr_r <= i_wdata[P_RW-1:0];
      if (i_addr == `CLDI_A_MAX_ACTIVE_TIME) max_time_r <= i_wdata[15:0];
      if (i_addr == `CLDI_A_ROUTE) route_r <= i_wdata[3:0];
      if (i_addr == `CLDI_A_SCALE) scale_r <= i_wdata[15:0];
      if (i_addr == `CLDI_A_IRQ_MASK) irq_mask_r <= i_wdata[4:0];
    end
  end

  // Events: cold start, cold trip, inrush start, inrush trip, inrush release
  assign events = {inr_release,
                   cold_det && (state_nxt == CLDI_TIMEOUT) && inr_det,
                   enter_act,
                   cold_det && (state_nxt == CLDI_TIMEOUT),
                   enter_act};

  // Sticky status, cleared by reading it; a new event wins over the clear
  assign irq_stat_nxt = (irq_stat_r & ~{5{rd_stat}}) | events;

  // (RL10) Read mux with primary scaled values; unmapped reads as zero
  always_comb begin
    case (i_addr)
      `CLDI_A_CTRL:     rd_mux = 32'(en_r);
      `CLDI_A_IDLE:     rd_mux = 32'(idle_thr_r);
      `CLDI_A_PICKUP:   rd_mux = 32'(pick_thr_r);
      `CLDI_A_HARM:     rd_mux = 32'(harm_thr_r);
      `CLDI_A_MAX_ACTIVE_TIME:  rd_mux = 32'(max_time_r);
      `CLDI_A_ROUTE:    rd_mux = 32'(route_r);
      `CLDI_A_SCALE:    rd_mux = 32'(scale_r);
      `CLDI_A_STATE:    rd_mux = 32'({inr_trip, inr_det, cold_trip, cold_det});
      `CLDI_A_MAXCUR:   rd_mux = 32'(max_cur_r);
      `CLDI_A_PRI_MAX:  rd_mux = (32'(max_cur_r) * 32'(scale_r)) >> `CLDI_SCALE_SHIFT;
      `CLDI_A_PRI_PICK: rd_mux = (32'(pick_thr_r) * 32'(scale_r)) >> `CLDI_SCALE_SHIFT;
      `CLDI_A_PRI_IDLE: rd_mux = (32'(idle_thr_r) * 32'(scale_r)) >> `CLDI_SCALE_SHIFT;
      `CLDI_A_IRQ_STAT: rd_mux = 32'(irq_stat_r);
      `CLDI_A_IRQ_MASK: rd_mux = 32'(irq_mask_r);
      default:          rd_mux = '0;
    endcase
  end

  // Read data, interrupt and status registers
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_rdata    <= '0;
      irq_stat_r <= '0;
      o_irq      <= 1'b0;
      max_cur_r  <= '0;
    end else begin
      o_rdata    <= i_rd ? rd_mux : '0;
      irq_stat_r <= irq_stat_nxt;
      o_irq      <= |(irq_stat_nxt & irq_mask_r);
      max_cur_r  <= max_cur;
    end
  end

  // (RL13) Routing to output matrix and blocking matrix
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_cold_outmx   <= 1'b0;
      o_cold_blkmx   <= 1'b0;
      o_inrush_outmx <= 1'b0;
      o_inrush_blkmx <= 1'b0;
    end else begin
      o_cold_outmx   <= cold_det && route_r[`CLDI_B_COLD_OUT];
      o_cold_blkmx   <= cold_det && route_r[`CLDI_B_COLD_BLK];
      o_inrush_outmx <= inr_det && route_r[`CLDI_B_INR_OUT];
      o_inrush_blkmx <= inr_det && route_r[`CLDI_B_INR_BLK];
    end
  end

  // Checks on the sequencer and harmonic decision
  property p_rise_detect;
    @(posedge i_ref_clk) disable iff (!rst_n_r)
    (state_r == CLDI_ARMED) && above_pick && en_r |=> (state_r == CLDI_ACTIVE) ##1 o_cold_blkmx == route_r[1];
  endproperty
  a_rise_detect: assert property (p_rise_detect) // RL1
    else $error("rise from idle did not start detection");

  property p_drop_end;
    @(posedge i_ref_clk) disable iff (!rst_n_r)
    cold_det && !above_pick |=> (state_r == CLDI_WAIT_IDLE) && !inr_det;
  endproperty
  a_drop_end: assert property (p_drop_end) // RL2
    else $error("detection did not end below pick-up");

  property p_linger;
    @(posedge i_ref_clk) disable iff (!rst_n_r)
    (state_r == CLDI_TRANSIT) && trans_exp && !above_pick && !all_idle |=> (state_r == CLDI_WAIT_IDLE);
  endproperty
  a_linger: assert property (p_linger) // RL12
    else $error("lingering current was not locked out");

  property p_early_block;
    @(posedge i_ref_clk) disable iff (!rst_n_r)
    $rose(cold_det) |-> inr_det && harm_pend_r;
  endproperty
  a_early_block: assert property (p_early_block) // RL5
    else $error("inrush not asserted at rise");

  property p_wait_cycle;
    @(posedge i_ref_clk) disable iff (!rst_n_r)
    harm_pend_r && cold_det && !i_cycle_done |=> harm_pend_r || !cold_det;
  endproperty
  a_wait_cycle: assert property (p_wait_cycle) // RL7
    else $error("harmonic decision taken before full cycle");

  property p_decide;
    @(posedge i_ref_clk) disable iff (!rst_n_r)
    cold_det && i_cycle_done |=> !harm_pend_r && (harm_keep_r == $past(harm_hit));
  endproperty
  a_decide: assert property (p_decide) // RL6
    else $error("harmonic keep or release wrong");

  property p_zero_thr;
    @(posedge i_ref_clk) disable iff (!rst_n_r)
    (harm_thr_r == '0) && cold_det && i_cycle_done && $stable(harm_thr_r) |=> harm_keep_r;
  endproperty
  a_zero_thr: assert property (p_zero_thr) // RL4
    else $error("zero threshold released inrush");

  property p_timeout;
    @(posedge i_ref_clk) disable iff (!rst_n_r)
    cold_det && act_exp && above_pick && en_r |=> cold_trip && !cold_det;
  endproperty
  a_timeout: assert property (p_timeout) // RL8
    else $error("maximum time did not give trip state");

  property p_need_idle;
    @(posedge i_ref_clk) disable iff (!rst_n_r)
    (state_r == CLDI_WAIT_IDLE) && !all_idle |=> !cold_det [*2];
  endproperty
  a_need_idle: assert property (p_need_idle) // RL11
    else $error("detection without prior idle");

  property p_no_harm;
    @(posedge i_ref_clk) disable iff (!rst_n_r)
    cold_det && i_cycle_done && !harm_hit |=> !inr_det;
  endproperty
  a_no_harm: assert property (p_no_harm) // RL3
    else $error("inrush kept without harmonic content");

endmodule // cldi_top

`default_nettype wire

//--- include/cldi_cfg.svh
// Offsets, reset values and timing constants of the cold load and inrush detector
`ifndef CLDI_CFG_SVH
`define CLDI_CFG_SVH

// Register byte addresses
`define CLDI_A_CTRL      8'h00
`define CLDI_A_IDLE      8'h04
`define CLDI_A_PICKUP    8'h08
`define CLDI_A_HARM      8'h0c
`define CLDI_A_MAX_ACTIVE_TIME   8'h10
`define CLDI_A_ROUTE     8'h14
`define CLDI_A_SCALE     8'h18
`define CLDI_A_STATE     8'h1c
`define CLDI_A_MAXCUR    8'h20
`define CLDI_A_PRI_MAX   8'h24
`define CLDI_A_PRI_PICK  8'h28
`define CLDI_A_PRI_IDLE  8'h2c
`define CLDI_A_IRQ_STAT  8'h30
`define CLDI_A_IRQ_MASK  8'h34

// Reset values
`define CLDI_R_CTRL      1'b1
`define CLDI_R_IDLE      16'h0010
`define CLDI_R_PICKUP    16'h0100
`define CLDI_R_HARM      16'h000a
`define CLDI_R_MAX_ACTIVE_TIME   16'h03e8
`define CLDI_R_ROUTE     4'hf
`define CLDI_R_SCALE     16'h0100
`define CLDI_R_MASK      5'h00

// Field positions
`define CLDI_B_EN         0
`define CLDI_B_COLD_OUT   0
`define CLDI_B_COLD_BLK   1
`define CLDI_B_INR_OUT    2
`define CLDI_B_INR_BLK    3
`define CLDI_SCALE_SHIFT  8

// Timing: clock period, one millisecond, transition window
`define CLDI_CLK_NS      10
`define CLDI_MS_NS       1000000
`define CLDI_MS_CYC      ((`CLDI_MS_NS + `CLDI_CLK_NS - 1) / `CLDI_CLK_NS)
`define CLDI_TRANS_MS    80

`endif

//--- include/cldi_pkg.sv
// Types shared by the cold load and inrush detector
package cldi_pkg;
  // Supervision sequence of the phase currents
  typedef enum logic [2:0] {
    CLDI_WAIT_IDLE,
    CLDI_ARMED,
    CLDI_TRANSIT,
    CLDI_ACTIVE,
    CLDI_TIMEOUT
  } cldi_state_t;

  typedef logic [7:0]  cldi_addr_t;
  typedef logic [31:0] cldi_word_t;
  typedef logic [4:0]  cldi_event_t;
endpackage

//--- tb/cldi_fe_model.sv
// Behavioural phase current and harmonic front end feeding the detector
`timescale 1ns/100ps
`default_nettype none

module cldi_fe_model (
  input  wire logic        i_ref_clk,
  input  wire logic [15:0] i_lvl,
  input  wire logic [15:0] i_ratio,
  input  wire logic        i_cyc_req,
  output logic      [15:0] o_cur_a,
  output logic      [15:0] o_cur_b,
  output logic      [15:0] o_cur_c,
  output logic      [15:0] o_ratio_a,
  output logic      [15:0] o_ratio_b,
  output logic      [15:0] o_ratio_c,
  output logic             o_cycle_done
);
  // Phase b carries the peak; only phase c shows second harmonic
  always_ff @(posedge i_ref_clk) begin
    o_cur_a   <= i_lvl >> 1;
    o_cur_b   <= i_lvl;
    o_cur_c   <= i_lvl >> 2;
    o_ratio_a <= 16'h0000;
    o_ratio_b <= 16'h0000;
    o_ratio_c <= i_ratio;
  end
  // full cycle result
  // One pulse for each completed analysis cycle
  always_ff @(posedge i_ref_clk) begin
    o_cycle_done <= i_cyc_req;
  end
endmodule // cldi_fe_model

`default_nettype wire

//--- tb/cldi_top_tb.sv
// Self-checking bench of the cold load and inrush detector
`include "cldi_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module cldi_top_tb;
  import cldi_pkg::*;
  logic        i_ref_clk = 1'b0;
  logic        i_resetn  = 1'b0;
  logic [15:0] lvl = 16'h0000;
  logic [15:0] ratio = 16'h0000;
  logic        cyc_req = 1'b0;
  logic [15:0] cur_a, cur_b, cur_c, rat_a, rat_b, rat_c;
  logic        cyc_done;
  cldi_addr_t  i_addr = 8'h00;
  cldi_word_t  i_wdata = 32'h0000_0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  cldi_word_t  o_rdata;
  logic        o_irq, c_out, c_blk, h_out, h_blk;
  int          err_total = 0;
  int          check_count = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  cldi_fe_model i_cldi_fe_model (.i_ref_clk(i_ref_clk), .i_lvl(lvl), .i_ratio(ratio),
    .i_cyc_req(cyc_req), .o_cur_a(cur_a), .o_cur_b(cur_b), .o_cur_c(cur_c),
    .o_ratio_a(rat_a), .o_ratio_b(rat_b), .o_ratio_c(rat_c), .o_cycle_done(cyc_done));

  cldi_top #(.P_MS_CYC(10)) i_cldi_top (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_cur_a(cur_a), .i_cur_b(cur_b), .i_cur_c(cur_c), .i_ratio_a(rat_a),
    .i_ratio_b(rat_b), .i_ratio_c(rat_c), .i_cycle_done(cyc_done), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_cold_outmx(c_out), .o_cold_blkmx(c_blk), .o_inrush_outmx(h_out),
    .o_inrush_blkmx(h_blk));

  task automatic wt(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask

  task automatic wr(input cldi_addr_t a, input cldi_word_t v);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  // Read data are taken in the cycle after the strobe
  task automatic rd(input cldi_addr_t a, output cldi_word_t v);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(posedge i_ref_clk);
    v = o_rdata;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rchk(input string n, input cldi_addr_t a, input cldi_word_t e);
    cldi_word_t v;
    rd(a, v);
    chk(n, e, v);
  endtask

  // Front end reports a finished cycle with the given ratio
  task automatic cyc(input logic [15:0] r);
    ratio <= r;
    wt(2);
    cyc_req <= 1'b1;
    @(posedge i_ref_clk);
    cyc_req <= 1'b0;
    wt(5);
  endtask

  // Sets the peak phase current and lets the outputs settle
  task automatic lv(input logic [15:0] v, input int n);
    lvl <= v;
    wt(n);
  endtask

  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    wt(30000);
    err_total++;
    end_of_test();
  end

  initial begin
    wt(12);
    i_resetn <= 1'b1;
    wt(3);
    rchk("ctrl", `CLDI_A_CTRL, 32'h1);
    rchk("idle", `CLDI_A_IDLE, 32'h10);
    rchk("pick", `CLDI_A_PICKUP, 32'h100);
    rchk("harm", `CLDI_A_HARM, 32'h0a);
    rchk("maxt", `CLDI_A_MAX_ACTIVE_TIME, 32'h3e8);
    rchk("route", `CLDI_A_ROUTE, 32'hf);
    rchk("scale", `CLDI_A_SCALE, 32'h100);
    rchk("mask", `CLDI_A_IRQ_MASK, 32'h0);
    rchk("unmapped", 8'h3c, 32'h0);
    $display("Test registers done");
    lv(16'h0200, 6);
    chk("cold", 1, c_out);
    chk("inr", 1, h_out);
    rchk("state", `CLDI_A_STATE, 32'h5);
    rchk("maxcur", `CLDI_A_MAXCUR, 32'h200);
    rchk("primax", `CLDI_A_PRI_MAX, 32'h200);
    rchk("pripick", `CLDI_A_PRI_PICK, 32'h100);
    cyc(16'h0005);
    chk("inr_rel", 0, h_out);
    chk("cold_kept", 1, c_blk);
    lv(16'h0080, 5);
    chk("cold_drop", 0, c_out);
    lv(16'h0200, 6);
    chk("no_idle", 0, c_out);
    $display("Test rise done");
    lv(16'h0000, 3);
    lv(16'h0080, 850);
    lv(16'h0200, 6);
    chk("linger", 0, c_out);
    lv(16'h0000, 3);
    lv(16'h0080, 700);
    lv(16'h0200, 6);
    chk("in_window", 1, c_out);
    lv(16'h0000, 6);
    $display("Test window done");
    rchk("stat_pre", `CLDI_A_IRQ_STAT, 32'h15);
    wr(`CLDI_A_MAX_ACTIVE_TIME, 32'd20);
    lv(16'h0200, 3);
    cyc(16'h0020);
    chk("inr_keep", 1, h_blk);
    chk("irq_masked", 0, o_irq);
    wt(250);
    chk("cold_tmo", 0, c_out);
    chk("inr_tmo", 0, h_out);
    rchk("state_trip", `CLDI_A_STATE, 32'ha);
    wr(`CLDI_A_IRQ_MASK, 32'h1f);
    wt(2);
    chk("irq", 1, o_irq);
    rchk("stat", `CLDI_A_IRQ_STAT, 32'h0f);
    rchk("stat_clr", `CLDI_A_IRQ_STAT, 32'h00);
    chk("irq_clr", 0, o_irq);
    lv(16'h0000, 6);
    $display("Test timeout done");
    wr(`CLDI_A_HARM, 32'h0);
    wr(`CLDI_A_ROUTE, 32'h5);
    wr(`CLDI_A_MAX_ACTIVE_TIME, 32'd100);
    rchk("route_rb", `CLDI_A_ROUTE, 32'h5);
    lv(16'h0200, 3);
    cyc(16'h0000);
    chk("inr_eq", 1, h_out);
    chk("inr_blk", 0, h_blk);
    chk("cold_out", 1, c_out);
    chk("cold_blk", 0, c_blk);
    lv(16'h0000, 6);
    $display("Test routing done");
    wr(`CLDI_A_SCALE, 32'h200);
    rchk("priidle", `CLDI_A_PRI_IDLE, 32'h20);
    wr(`CLDI_A_CTRL, 32'h0);
    lv(16'h0200, 6);
    chk("disabled", 0, c_out);
    wr(`CLDI_A_CTRL, 32'h1);
    wt(3);
    chk("en_no_idle", 0, c_out);
    lv(16'h0000, 6);
    $display("Test enable done");
    end_of_test();
  end
endmodule // cldi_top_tb

`default_nettype wire
